/* hw/sxs_pkg.sv */
package sxs_pkg;

  // ----------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------
  localparam int INSTR_W  = 14;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  localparam int FDEPTH   = 128;

  // ----------------------------------------------------------------
  // Opcode patterns and field positions
  // ----------------------------------------------------------------
  localparam logic [4:0]  OPC_SUB_LIT   = 5'h1E;
  localparam logic [5:0]  OPC_XOR_LIT   = 6'h3A;
  localparam logic [5:0]  OPC_SUB_FILE  = 6'h02;
  localparam logic [5:0]  OPC_XOR_FILE  = 6'h06;
  localparam logic [5:0]  OPC_SWAP_FILE = 6'h0E;
  localparam logic [10:0] OPC_DIR_LOAD  = 11'h00C;
  localparam int          DEST_BIT      = 7;
  localparam logic [2:0]  DIR_PORT_A    = 3'h5;
  localparam logic [2:0]  DIR_PORT_B    = 3'h6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WREG_RST      = 8'h00;
  localparam logic [7:0]  DIR_RST       = 8'hFF;
  localparam logic        FLAG_RST      = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SXS_OP_NONE  = 3'h0,
    SXS_OP_SUBL  = 3'h1,
    SXS_OP_SUBF  = 3'h2,
    SXS_OP_DIRLD = 3'h3,
    SXS_OP_SWAP  = 3'h4,
    SXS_OP_XORL  = 3'h5,
    SXS_OP_XORF  = 3'h6
  } sxs_op_e;

  typedef enum logic {
    SXS_ST_IDLE = 1'b0,
    SXS_ST_EXEC = 1'b1
  } sxs_state_e;

endpackage

/* hw/sxs_file_mem.sv */
module sxs_file_mem #(
  parameter int ADDR_W = 7,
  parameter int DEPTH  = 128,
  parameter int WIDTH  = 8
) (
  input  wire logic              core_clk,
  input  wire logic              core_ce,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WIDTH-1:0]  rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data
);

  // ----------------------------------------------------------------
  // Storage, no reset: contents are undefined until written
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  always_ff @(posedge core_clk) begin
    if (core_ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (core_ce && rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule

/* hw/sxs_exec_core.sv */
// Behaviour
// - Literal minus W goes into W, flags updated
// - Carry set unless subtraction result is negative
// - File minus W, carry, digit carry, zero
// - Destination bit picks W or file
// - W loads direction register 5 or 6
// - Swap nibbles of file, flags untouched
// - W xor literal into W, zero only
// - W xor file, routed, zero only
module sxs_exec_core #(
  parameter int ADDR_W = sxs_pkg::FADDR_W,
  parameter int DEPTH  = sxs_pkg::FDEPTH
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         core_ce,
  input  wire logic                         instr_valid,
  input  wire logic [sxs_pkg::INSTR_W-1:0]  instr_word,
  input  wire logic                         load_en,
  input  wire logic [ADDR_W-1:0]            load_addr,
  input  wire logic [sxs_pkg::DATA_W-1:0]   load_data,
  output logic                              instr_ready,
  output logic                              exec_done,
  output logic                              exec_illegal,
  output logic [sxs_pkg::DATA_W-1:0]        result_data,
  output logic                              result_to_file,
  output logic [ADDR_W-1:0]                 result_addr,
  output logic [sxs_pkg::DATA_W-1:0]        wreg_value,
  output logic                              carry_flag,
  output logic                              digit_carry_flag,
  output logic                              zero_flag,
  output logic [sxs_pkg::DATA_W-1:0]        port_dir_a,
  output logic [sxs_pkg::DATA_W-1:0]        port_dir_b
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sxs_pkg::sxs_state_e             state_reg;
  sxs_pkg::sxs_op_e                op_reg;
  sxs_pkg::sxs_op_e                op_next;
  logic [sxs_pkg::INSTR_W-1:0]     instr_reg;
  logic [7:0]                      wreg_reg;
  logic                            carry_reg;
  logic                            dig_carry_reg;
  logic                            zero_reg;
  logic [7:0]                      dir_a_reg;
  logic [7:0]                      dir_b_reg;
  logic                            ready_reg;
  logic                            done_reg;
  logic                            illegal_reg;
  logic [7:0]                      result_reg;
  logic                            to_file_reg;
  logic [ADDR_W-1:0]               res_addr_reg;
  logic                            take;
  logic                            exec;
  logic [7:0]                      file_rd;
  logic [7:0]                      lit;
  logic [7:0]                      sub_a;
  logic [8:0]                      sub_full;
  logic [4:0]                      sub_nib;
  logic [7:0]                      res_next;
  logic                            dest_file;
  logic                            file_op;
  logic                            mem_wr_en;
  logic [ADDR_W-1:0]               mem_wr_addr;
  logic [7:0]                      mem_wr_data;
  logic                            ce_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    op_next = sxs_pkg::SXS_OP_NONE;
    if (instr_word[13:9] == sxs_pkg::OPC_SUB_LIT) begin
      op_next = sxs_pkg::SXS_OP_SUBL;
    end else if (instr_word[13:8] == sxs_pkg::OPC_XOR_LIT) begin
      op_next = sxs_pkg::SXS_OP_XORL;
    end else if (instr_word[13:8] == sxs_pkg::OPC_SUB_FILE) begin
      op_next = sxs_pkg::SXS_OP_SUBF;
    end else if (instr_word[13:8] == sxs_pkg::OPC_XOR_FILE) begin
      op_next = sxs_pkg::SXS_OP_XORF;
    end else if (instr_word[13:8] == sxs_pkg::OPC_SWAP_FILE) begin
      op_next = sxs_pkg::SXS_OP_SWAP;
    end else if (instr_word[13:3] == sxs_pkg::OPC_DIR_LOAD &&
                 (instr_word[2:0] == sxs_pkg::DIR_PORT_A ||
                  instr_word[2:0] == sxs_pkg::DIR_PORT_B)) begin
      op_next = sxs_pkg::SXS_OP_DIRLD;
    end
  end

  assign take = core_ce && ready_reg && state_reg == sxs_pkg::SXS_ST_IDLE && instr_valid;
  assign exec = core_ce && state_reg == sxs_pkg::SXS_ST_EXEC;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= sxs_pkg::SXS_ST_IDLE;
      ready_reg <= 1'b0;
    end else if (core_ce) begin
      if (take && op_next != sxs_pkg::SXS_OP_NONE) begin
        state_reg <= sxs_pkg::SXS_ST_EXEC;
        ready_reg <= 1'b0;
      end else begin
        state_reg <= sxs_pkg::SXS_ST_IDLE;
        ready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      instr_reg <= '0;
      op_reg    <= sxs_pkg::SXS_OP_NONE;
    end else if (take) begin
      instr_reg <= instr_word;
      op_reg    <= op_next;
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  assign lit       = instr_reg[7:0];
  assign dest_file = instr_reg[sxs_pkg::DEST_BIT];
  assign file_op   = op_reg == sxs_pkg::SXS_OP_SUBF || op_reg == sxs_pkg::SXS_OP_XORF ||
                     op_reg == sxs_pkg::SXS_OP_SWAP;
  assign sub_a     = (op_reg == sxs_pkg::SXS_OP_SUBL) ? lit : file_rd;
  // Add of the inverted W plus one: carry out is the inverted borrow
  assign sub_full  = {1'b0, sub_a} + {1'b0, ~wreg_reg} + 9'h001;
  assign sub_nib   = {1'b0, sub_a[3:0]} + {1'b0, ~wreg_reg[3:0]} + 5'h01;

  always_comb begin
    res_next = 8'h00;
    unique case (op_reg)
      sxs_pkg::SXS_OP_SUBL,
      sxs_pkg::SXS_OP_SUBF:  res_next = sub_full[7:0];
      sxs_pkg::SXS_OP_XORL:  res_next = wreg_reg ^ lit;
      sxs_pkg::SXS_OP_XORF:  res_next = wreg_reg ^ file_rd;
      sxs_pkg::SXS_OP_SWAP:  res_next = {file_rd[3:0], file_rd[7:4]};
      sxs_pkg::SXS_OP_DIRLD: res_next = wreg_reg;
      default:               res_next = 8'h00;
    endcase
  end

  // Loader only reaches memory when no instruction is taken
  assign mem_wr_en   = (exec && file_op && dest_file) ||
                       (load_en && core_ce && state_reg == sxs_pkg::SXS_ST_IDLE && !take);
  assign mem_wr_addr = exec ? instr_reg[ADDR_W-1:0] : load_addr;
  assign mem_wr_data = exec ? res_next : load_data;

  sxs_file_mem #(
    .ADDR_W (ADDR_W),
    .DEPTH  (DEPTH),
    .WIDTH  (sxs_pkg::DATA_W)
  ) u_mem (
    .core_clk (core_clk),
    .core_ce  (core_ce),
    .rd_en    (take),
    .rd_addr  (instr_word[ADDR_W-1:0]),
    .rd_data  (file_rd),
    .wr_en    (mem_wr_en),
    .wr_addr  (mem_wr_addr),
    .wr_data  (mem_wr_data)
  );

  // ----------------------------------------------------------------
  // Working register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wreg_reg <= sxs_pkg::WREG_RST;
    end else if (exec) begin
      if (op_reg == sxs_pkg::SXS_OP_SUBL || op_reg == sxs_pkg::SXS_OP_XORL) begin
        wreg_reg <= res_next;
      end else if (file_op && !dest_file) begin
        wreg_reg <= res_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      carry_reg <= sxs_pkg::FLAG_RST;
      dig_carry_reg <= sxs_pkg::FLAG_RST;
      zero_reg  <= sxs_pkg::FLAG_RST;
    end else if (exec) begin
      unique case (op_reg)
        sxs_pkg::SXS_OP_SUBL,
        sxs_pkg::SXS_OP_SUBF: begin
          carry_reg <= sub_full[8];
          dig_carry_reg <= sub_nib[4];
          zero_reg  <= sub_full[7:0] == 8'h00;
        end
        sxs_pkg::SXS_OP_XORL,
        sxs_pkg::SXS_OP_XORF: begin
          zero_reg  <= res_next == 8'h00;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Port direction registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dir_a_reg <= sxs_pkg::DIR_RST;
      dir_b_reg <= sxs_pkg::DIR_RST;
    end else if (exec && op_reg == sxs_pkg::SXS_OP_DIRLD) begin
      if (instr_reg[2:0] == sxs_pkg::DIR_PORT_A) begin
        dir_a_reg <= wreg_reg;
      end else begin
        dir_b_reg <= wreg_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion report
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      done_reg     <= 1'b0;
      illegal_reg  <= 1'b0;
      result_reg   <= 8'h00;
      to_file_reg  <= 1'b0;
      res_addr_reg <= '0;
    end else if (core_ce) begin
      done_reg    <= exec;
      illegal_reg <= take && op_next == sxs_pkg::SXS_OP_NONE;
      if (exec) begin
        result_reg   <= res_next;
        to_file_reg  <= file_op && dest_file;
        res_addr_reg <= instr_reg[ADDR_W-1:0];
      end
    end
  end

  assign instr_ready      = ready_reg;
  assign exec_done        = done_reg;
  assign exec_illegal     = illegal_reg;
  assign result_data      = result_reg;
  assign result_to_file   = to_file_reg;
  assign result_addr      = res_addr_reg;
  assign wreg_value       = wreg_reg;
  assign carry_flag       = carry_reg;
  assign digit_carry_flag = dig_carry_reg;
  assign zero_flag        = zero_reg;
  assign port_dir_a       = dir_a_reg;
  assign port_dir_b       = dir_b_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    ce_d <= core_ce;
  end

  chk_sub_lit_value: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) == sxs_pkg::SXS_OP_SUBL) |->
      wreg_reg == 8'($past(instr_reg[7:0]) - $past(wreg_reg)))
    else $error("literal subtract gave wrong W");

  chk_borrow_carry: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && ($past(op_reg) == sxs_pkg::SXS_OP_SUBL ||
                          $past(op_reg) == sxs_pkg::SXS_OP_SUBF)) |->
      carry_reg == ($past(sub_a) >= $past(wreg_reg)))
    else $error("carry is not the inverted borrow");

  chk_sub_file_value: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) == sxs_pkg::SXS_OP_SUBF) |->
      result_reg == 8'($past(file_rd) - $past(wreg_reg)))
    else $error("file subtract gave wrong result");

  chk_dest_route: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(file_op)) |->
      (result_to_file == $past(instr_reg[7])) &&
      (result_to_file ? wreg_reg == $past(wreg_reg) : wreg_reg == result_reg))
    else $error("result routed to wrong destination");

  chk_dir_load: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) == sxs_pkg::SXS_OP_DIRLD) |->
      (($past(instr_reg[2:0]) == sxs_pkg::DIR_PORT_A ? dir_a_reg : dir_b_reg)
        == $past(wreg_reg)) && $stable({carry_reg, dig_carry_reg, zero_reg}))
    else $error("direction load wrong or flags moved");

  chk_swap_nibble: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) == sxs_pkg::SXS_OP_SWAP) |->
      result_reg == {$past(file_rd[3:0]), $past(file_rd[7:4])} &&
      $stable({carry_reg, dig_carry_reg, zero_reg}))
    else $error("nibble swap wrong or flags moved");

  chk_xor_literal: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) == sxs_pkg::SXS_OP_XORL) |->
      wreg_reg == ($past(wreg_reg) ^ $past(instr_reg[7:0])) &&
      $stable({carry_reg, dig_carry_reg}))
    else $error("literal xor wrong or extra flags moved");

  chk_xor_file: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) == sxs_pkg::SXS_OP_XORF) |->
      result_reg == ($past(wreg_reg) ^ $past(file_rd)) && $stable({carry_reg, dig_carry_reg}))
    else $error("file xor wrong or extra flags moved");

  chk_zero_digit: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ce_d && done_reg && $past(op_reg) != sxs_pkg::SXS_OP_SWAP &&
     $past(op_reg) != sxs_pkg::SXS_OP_DIRLD) |->
      zero_reg == (result_reg == 8'h00) &&
      ($past(op_reg) == sxs_pkg::SXS_OP_XORL || $past(op_reg) == sxs_pkg::SXS_OP_XORF ||
       dig_carry_reg == ($past(sub_a[3:0]) >= $past(wreg_reg[3:0]))))
    else $error("zero or digit carry flag wrong");

endmodule

/* verification/sxs_exec_core_tb.sv */
module sxs_exec_core_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and shadow state
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        sys_rst;
  logic        core_ce;
  logic        instr_valid;
  logic [13:0] instr_word;
  logic        load_en;
  logic [6:0]  load_addr;
  logic [7:0]  load_data;
  logic        instr_ready;
  logic        exec_done;
  logic        exec_illegal;
  logic [7:0]  result_data;
  logic        result_to_file;
  logic [6:0]  result_addr;
  logic [7:0]  wreg_value;
  logic        carry_flag;
  logic        digit_carry_flag;
  logic        zero_flag;
  logic [7:0]  port_dir_a;
  logic [7:0]  port_dir_b;
  logic [7:0]  mem_m [128];
  logic [7:0]  w_m, dir_a_m, dir_b_m, res_m;
  logic        c_m, dig_c_m, z_m, tof_m;
  logic [6:0]  addr_m;
  int          error_cnt;
  int          checks_done;
  int unsigned seed_val;

  sxs_exec_core #(.ADDR_W(sxs_pkg::FADDR_W), .DEPTH(sxs_pkg::FDEPTH)) sxs_exec_core_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .instr_ready(instr_ready), .exec_done(exec_done), .exec_illegal(exec_illegal),
    .result_data(result_data), .result_to_file(result_to_file), .result_addr(result_addr),
    .wreg_value(wreg_value), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag), .port_dir_a(port_dir_a), .port_dir_b(port_dir_b));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_state();
    cmp_byte("wreg_value", w_m, wreg_value);
    cmp_bit("carry_flag", c_m, carry_flag);
    cmp_bit("digit_carry_flag", dig_c_m, digit_carry_flag);
    cmp_bit("zero_flag", z_m, zero_flag);
    cmp_byte("port_dir_a", dir_a_m, port_dir_a);
    cmp_byte("port_dir_b", dir_b_m, port_dir_b);
    cmp_byte("result_data", res_m, result_data);
    cmp_bit("result_to_file", tof_m, result_to_file);
    cmp_byte("result_addr", {1'b0, addr_m}, {1'b0, result_addr});
  endtask

  // ----------------------------------------------------------------
  // Expected behaviour
  // ----------------------------------------------------------------
  // Updates the shadow state; returns 0 for a word the block must refuse
  function automatic bit apply_model(input logic [13:0] iw);
    logic [7:0] f;
    logic [7:0] r;
    bit         fop;
    f   = mem_m[iw[6:0]];
    fop = 1'b1;
    if (iw[13:9] == sxs_pkg::OPC_SUB_LIT) begin
      r = iw[7:0] - w_m;
      c_m = iw[7:0] >= w_m;
      dig_c_m = iw[3:0] >= w_m[3:0];
      z_m = (r == 8'h00);
      w_m = r;
      fop = 1'b0;
    end else if (iw[13:8] == sxs_pkg::OPC_XOR_LIT) begin
      r = w_m ^ iw[7:0];
      z_m = (r == 8'h00);
      w_m = r;
      fop = 1'b0;
    end else if (iw[13:8] == sxs_pkg::OPC_SUB_FILE) begin
      r = f - w_m;
      c_m = f >= w_m;
      dig_c_m = f[3:0] >= w_m[3:0];
      z_m = (r == 8'h00);
    end else if (iw[13:8] == sxs_pkg::OPC_XOR_FILE) begin
      r = w_m ^ f;
      z_m = (r == 8'h00);
    end else if (iw[13:8] == sxs_pkg::OPC_SWAP_FILE) begin
      r = {f[3:0], f[7:4]};
    end else if (iw[13:3] == sxs_pkg::OPC_DIR_LOAD && iw[2:0] == sxs_pkg::DIR_PORT_A) begin
      r = w_m;
      dir_a_m = w_m;
      fop = 1'b0;
    end else if (iw[13:3] == sxs_pkg::OPC_DIR_LOAD && iw[2:0] == sxs_pkg::DIR_PORT_B) begin
      r = w_m;
      dir_b_m = w_m;
      fop = 1'b0;
    end else begin
      return 1'b0;
    end
    res_m  = r;
    addr_m = iw[6:0];
    tof_m  = fop & iw[sxs_pkg::DEST_BIT];
    if (tof_m) begin
      mem_m[iw[6:0]] = r;
    end else if (fop) begin
      w_m = r;
    end
    return 1'b1;
  endfunction

  function automatic logic [13:0] rand_word(input int k);
    case (k)
      0: return {sxs_pkg::OPC_SUB_LIT, 9'($urandom)};
      1: return {sxs_pkg::OPC_XOR_LIT, 8'($urandom)};
      2: return {sxs_pkg::OPC_SUB_FILE, 8'($urandom)};
      3: return {sxs_pkg::OPC_XOR_FILE, 8'($urandom)};
      4: return {sxs_pkg::OPC_SWAP_FILE, 8'($urandom)};
      5: return {sxs_pkg::OPC_DIR_LOAD, 3'($urandom_range(4, 7))};
      default: return 14'($urandom);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic do_reset();
    sys_rst     = 1'b1;
    instr_valid = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    cmp_bit("instr_ready", 1'b0, instr_ready);
    sys_rst = 1'b0;
    {w_m, res_m, addr_m, c_m, dig_c_m, z_m, tof_m} = '0;
    dir_a_m = 8'hFF;
    dir_b_m = 8'hFF;
    @(posedge core_clk);
    #1;
    cmp_bit("instr_ready", 1'b1, instr_ready);
    check_state();
  endtask

  // Hold keeps valid and a preload up while busy; both must be ignored
  task automatic do_instr(input logic [13:0] iw, input bit hold, input bit stall);
    instr_word  = iw;
    instr_valid = 1'b1;
    @(posedge core_clk);
    #1;
    if (!apply_model(iw)) begin
      cmp_bit("exec_illegal", 1'b1, exec_illegal);
      cmp_bit("instr_ready", 1'b1, instr_ready);
      check_state();
      return;
    end
    instr_valid = hold;
    instr_word  = ~iw;
    load_en     = hold;
    load_addr   = iw[6:0];
    load_data   = ~mem_m[iw[6:0]];
    cmp_bit("instr_ready", 1'b0, instr_ready);
    if (stall) begin
      core_ce = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      cmp_bit("exec_done", 1'b0, exec_done);
      core_ce = 1'b1;
    end
    @(posedge core_clk);
    #1;
    load_en     = 1'b0;
    cmp_bit("exec_done", 1'b1, exec_done);
    check_state();
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {core_clk, instr_word, load_en, load_addr, load_data} = '0;
    core_ce     = 1'b1;
    error_cnt   = 0;
    checks_done = 0;
    seed_val    = $urandom(57107);
    do_reset();
    for (int a = 0; a < 128; a++) begin
      load_en   = 1'b1;
      load_addr = 7'(a);
      load_data = 8'($urandom);
      mem_m[a]  = load_data;
      @(posedge core_clk);
      #1;
    end
    load_en = 1'b0;
    do_instr({sxs_pkg::OPC_SUB_LIT, 9'h100}, 0, 0);
    do_instr({sxs_pkg::OPC_XOR_LIT, 8'h5A}, 0, 0);
    do_instr({sxs_pkg::OPC_SUB_LIT, 9'h059}, 0, 0);
    do_instr({sxs_pkg::OPC_DIR_LOAD, sxs_pkg::DIR_PORT_A}, 0, 0);
    do_instr({sxs_pkg::OPC_XOR_LIT, 8'h3C}, 0, 0);
    do_instr({sxs_pkg::OPC_DIR_LOAD, sxs_pkg::DIR_PORT_B}, 0, 0);
    do_instr({sxs_pkg::OPC_DIR_LOAD, 3'h7}, 0, 0);
    do_instr({sxs_pkg::OPC_DIR_LOAD, 3'h4}, 0, 0);
    do_instr({sxs_pkg::OPC_XOR_LIT, w_m ^ mem_m[3]}, 0, 0);
    do_instr({sxs_pkg::OPC_SUB_FILE, 8'h83}, 0, 0);
    do_instr({sxs_pkg::OPC_SWAP_FILE, 8'h03}, 1, 0);
    do_instr({sxs_pkg::OPC_XOR_FILE, 8'h03}, 0, 1);
    for (int k = 2; k < 5; k++) begin
      do_instr({rand_word(k)} & 14'h3F7F, 0, 0);
      do_instr({rand_word(k)} | 14'h0080, 0, 0);
    end
    repeat (300) begin
      do_instr(rand_word($urandom_range(0, 6)), $urandom_range(0, 3) == 0,
               $urandom_range(0, 9) == 0);
    end
    do_reset();
    repeat (40) begin
      do_instr(rand_word($urandom_range(0, 6)), 0, 0);
    end
    print_verdict();
  end

  // Generous bound: the sequence needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    error_cnt++;
    $display("MISMATCH watchdog expected end of tests seen timeout");
    print_verdict();
  end

endmodule
